// File: dual_timer_output_compare_defines.vh
// Purpose: constants for the dual timer output compare block
// Assumes: included by dual_timer_output_compare.v
// Notes: count source codes are 3-bit fields of the source select input
`ifndef DUAL_TIMER_OUTPUT_COMPARE_DEFINES_VH
`define DUAL_TIMER_OUTPUT_COMPARE_DEFINES_VH

`define TMR_WIDTH        16
`define TMR_RESET        16'h0000
`define CMP_RESET        16'h0000
`define SRC_DIV2         3'h0
`define SRC_DIV16        3'h1
`define SRC_DIV32        3'h2
`define SRC_DIV64        3'h3
`define SRC_DIV128       3'h4
`define SRC_DIV256       3'h5
`define SRC_ALT          3'h6
`define SRC_A_LSB        0
`define SRC_A_MSB        2
`define SRC_B_LSB        4
`define SRC_B_MSB        6
`define DIV_MASK2        8'h01
`define DIV_MASK16       8'h0f
`define DIV_MASK32       8'h1f
`define DIV_MASK64       8'h3f
`define DIV_MASK128      8'h7f
`define DIV_MASK256      8'hff

`endif

// File: dual_timer_output_compare.v
// Purpose: two 16-bit reloadable down timers driving four output compare channels
// Assumes: all inputs synchronous to mclk; write/read strobes are one-cycle pulses
// Notes: the on-chip oscillator arrives as a sampled level; its rising edge is a count tick
// Behaviour
// - Each timer decrements per count tick; after zero it reloads latch and flags underflow.
// - Latch value n gives one underflow every n+1 count ticks.
// - First timer counts main clock /2,/16,/32,/64,/128,/256 or on-chip oscillator.
// - Second timer counts the same divisions or first timer underflows.
// - Write control 0 loads latch and counter; 1 loads latch only, even stopped.
// - Timer byte reads return the counter (low byte snapshotted at the high read), never the latch.
// - Four compare channels, each picking either timer through its own source bit.
// - A set reload bit moves the compare register into its latch at next underflow.
// - Counter equal to a compare latch raises a compare trigger.
// - Trigger enable 1 lets matches change output; 0 holds the output level.
// - Polarity 0: first latch drives high, second low; polarity 1 reverses.
// - Per-channel status shows present compare output level.
// - Each latch match requests interrupt when its own enable bit is set.
// - Modulation drives AND of paired channel outputs on the even channel pin.
// - With source timer stopped, compare loads reach the latch without waiting.
// - Latch above reload value never matches; other latches still signal.
// - Matches still request interrupts while trigger enable is cleared.
`timescale 1ns/1ps
`include "dual_timer_output_compare_defines.vh"
`default_nettype none

module dual_timer_output_compare #(
  parameter integer CHANNELS = 4
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        onchip_osc,
  input  wire [7:0]  timer_clock_source_select,
  input  wire        first_timer_stop,
  input  wire        second_timer_stop,
  input  wire        first_timer_write_latch_only,
  input  wire        second_timer_write_latch_only,
  input  wire [7:0]  wr_data,
  input  wire        first_timer_low_wr,
  input  wire        first_timer_high_wr,
  input  wire        second_timer_low_wr,
  input  wire        second_timer_high_wr,
  input  wire        first_timer_high_rd,
  input  wire        second_timer_high_rd,
  output reg  [7:0]  first_timer_low_byte,
  output wire [7:0]  first_timer_high_byte,
  output reg  [7:0]  second_timer_low_byte,
  output wire [7:0]  second_timer_high_byte,
  output reg         first_timer_underflow_irq,
  output reg         second_timer_underflow_irq,
  input  wire [1:0]  cmp_write_pointer,
  input  wire        cmp_low_wr,
  input  wire        cmp_high_wr,
  input  wire [7:0]  cmp_reload_set,
  input  wire [3:0]  cmp_timer_source,
  input  wire [3:0]  cmp_trigger_en,
  input  wire [3:0]  cmp_polarity,
  input  wire [7:0]  cmp_int_en,
  input  wire [3:0]  cmp_port_en,
  input  wire [1:0]  cmp_modulation_en,
  output reg  [7:0]  cmp_reload_pending,
  output wire [3:0]  cmp_output_status,
  output reg         cmp_irq_req,
  output reg  [7:0]  cmp_match_pulse,
  output reg  [3:0]  compare_pin_out,
  output wire [3:0]  compare_pin_oe
);

  // Picks the prescaler tap for a 3-bit source code
  function tap_tick;
    input [2:0] code;
    input [7:0] div;
    input       alt;
    begin
      case (code)
        `SRC_DIV2:   tap_tick = ((div & `DIV_MASK2) == `DIV_MASK2);
        `SRC_DIV16:  tap_tick = ((div & `DIV_MASK16) == `DIV_MASK16);
        `SRC_DIV32:  tap_tick = ((div & `DIV_MASK32) == `DIV_MASK32);
        `SRC_DIV64:  tap_tick = ((div & `DIV_MASK64) == `DIV_MASK64);
        `SRC_DIV128: tap_tick = ((div & `DIV_MASK128) == `DIV_MASK128);
        `SRC_DIV256: tap_tick = ((div & `DIV_MASK256) == `DIV_MASK256);
        `SRC_ALT:    tap_tick = alt;
        default:     tap_tick = 1'b0;
      endcase
    end
  endfunction

  reg  [7:0]            div_ff;
  reg                   osc_prev_ff;
  reg  [7:0]            a_stage_ff;
  reg  [7:0]            b_stage_ff;
  reg  [`TMR_WIDTH-1:0] a_cnt_ff;
  reg  [`TMR_WIDTH-1:0] a_latch_ff;
  reg  [`TMR_WIDTH-1:0] b_cnt_ff;
  reg  [`TMR_WIDTH-1:0] b_latch_ff;
  reg                   a_upd_ff;
  reg                   b_upd_ff;
  reg  [`TMR_WIDTH-1:0] cmp_reg_ff [0:CHANNELS-1];
  reg  [`TMR_WIDTH-1:0] cmp_latch_ff [0:2*CHANNELS-1];
  reg  [3:0]            out_ff;
  reg  [7:0]            cmp_lo_stage_ff;
  reg  [7:0]            nxt_match;
  reg  [7:0]            nxt_pending;
  reg  [3:0]            nxt_out;
  reg  [7:0]            nxt_load;
  wire                  osc_rise;
  wire                  a_tick;
  wire                  b_tick;
  wire                  a_uf;
  wire                  b_uf;
  wire [`TMR_WIDTH-1:0] a_wr_val;
  wire [`TMR_WIDTH-1:0] b_wr_val;
  wire [`TMR_WIDTH-1:0] cmp_wr_val;
  integer               i;
  integer               j;

  assign osc_rise = onchip_osc & ~osc_prev_ff;
  assign a_tick   = ~first_timer_stop &
                    tap_tick(timer_clock_source_select[`SRC_A_MSB:`SRC_A_LSB], div_ff, osc_rise);
  assign a_uf     = a_tick & (a_cnt_ff == `TMR_RESET);
  // Cascade tick is the underflow pulse of the first timer
  assign b_tick   = ~second_timer_stop &
                    tap_tick(timer_clock_source_select[`SRC_B_MSB:`SRC_B_LSB], div_ff, a_uf);
  assign b_uf     = b_tick & (b_cnt_ff == `TMR_RESET);
  assign a_wr_val   = {wr_data, a_stage_ff};
  assign b_wr_val   = {wr_data, b_stage_ff};
  assign cmp_wr_val = {wr_data, cmp_lo_stage_ff};

  assign first_timer_high_byte  = a_cnt_ff[15:8];
  assign second_timer_high_byte = b_cnt_ff[15:8];

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      div_ff      <= 8'h00;
      osc_prev_ff <= 1'b0;
    end
    else
    begin
      div_ff      <= div_ff + 8'h01;
      osc_prev_ff <= onchip_osc;
    end
  end

  // First timer; high-byte write commits the staged low byte
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      a_stage_ff                <= 8'h00;
      a_cnt_ff                  <= `TMR_RESET;
      a_latch_ff                <= `TMR_RESET;
      a_upd_ff                  <= 1'b0;
      first_timer_underflow_irq <= 1'b0;
      first_timer_low_byte      <= 8'h00;
    end
    else
    begin
      a_upd_ff                  <= a_tick;
      first_timer_underflow_irq <= a_uf;
      if (first_timer_low_wr)
        a_stage_ff <= wr_data;
      // Low byte snapshot keeps a high-then-low read coherent
      if (first_timer_high_rd)
        first_timer_low_byte <= a_cnt_ff[7:0];
      if (first_timer_high_wr)
      begin
        a_latch_ff <= a_wr_val;
        if (!first_timer_write_latch_only)
          a_cnt_ff <= a_wr_val;
      end
      else if (a_uf)
        a_cnt_ff <= a_latch_ff;
      else if (a_tick)
        a_cnt_ff <= a_cnt_ff - 16'h0001;
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      b_stage_ff                 <= 8'h00;
      b_cnt_ff                   <= `TMR_RESET;
      b_latch_ff                 <= `TMR_RESET;
      b_upd_ff                   <= 1'b0;
      second_timer_underflow_irq <= 1'b0;
      second_timer_low_byte      <= 8'h00;
    end
    else
    begin
      b_upd_ff                   <= b_tick;
      second_timer_underflow_irq <= b_uf;
      if (second_timer_low_wr)
        b_stage_ff <= wr_data;
      if (second_timer_high_rd)
        second_timer_low_byte <= b_cnt_ff[7:0];
      if (second_timer_high_wr)
      begin
        b_latch_ff <= b_wr_val;
        if (!second_timer_write_latch_only)
          b_cnt_ff <= b_wr_val;
      end
      else if (b_uf)
        b_cnt_ff <= b_latch_ff;
      else if (b_tick)
        b_cnt_ff <= b_cnt_ff - 16'h0001;
    end
  end

  // Matches are sampled once per new count value so a stopped timer does not refire
  always @*
  begin
    nxt_match   = 8'h00;
    nxt_pending = cmp_reload_pending | cmp_reload_set;
    nxt_load    = 8'h00;
    nxt_out     = out_ff;
    for (i = 0; i < 2*CHANNELS; i = i + 1)
    begin
      if (cmp_timer_source[i/2])
        nxt_match[i] = b_upd_ff & (b_cnt_ff == cmp_latch_ff[i]);
      else
        nxt_match[i] = a_upd_ff & (a_cnt_ff == cmp_latch_ff[i]);
      // Stopped source loads at once; running source waits for its underflow
      if (cmp_timer_source[i/2] ? (second_timer_stop | b_uf) : (first_timer_stop | a_uf))
        nxt_load[i] = nxt_pending[i];
    end
    nxt_pending = nxt_pending & ~nxt_load;
    for (i = 0; i < CHANNELS; i = i + 1)
    begin
      if (cmp_trigger_en[i])
      begin
        if (nxt_match[2*i+1])
          nxt_out[i] = cmp_polarity[i];
        else if (nxt_match[2*i])
          nxt_out[i] = ~cmp_polarity[i];
      end
    end
  end

  // Compare staging, reload and output levels
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cmp_lo_stage_ff    <= 8'h00;
      cmp_reload_pending <= 8'h00;
      cmp_match_pulse    <= 8'h00;
      cmp_irq_req        <= 1'b0;
      out_ff             <= 4'h0;
      for (j = 0; j < CHANNELS; j = j + 1)
        cmp_reg_ff[j] <= `CMP_RESET;
      for (j = 0; j < 2*CHANNELS; j = j + 1)
        cmp_latch_ff[j] <= `CMP_RESET;
    end
    else
    begin
      out_ff          <= nxt_out;
      cmp_match_pulse <= nxt_match;
      cmp_irq_req     <= |(nxt_match & cmp_int_en);
      if (cmp_low_wr)
        cmp_lo_stage_ff <= wr_data;
      if (cmp_high_wr)
        cmp_reg_ff[cmp_write_pointer] <= cmp_wr_val;
      // Load strobes are decoded together with the pending bits
      for (j = 0; j < 2*CHANNELS; j = j + 1)
      begin
        if (nxt_load[j])
          cmp_latch_ff[j] <= cmp_reg_ff[j/2];
      end
      cmp_reload_pending <= nxt_pending;
    end
  end

  assign cmp_output_status = out_ff;
  assign compare_pin_oe    = cmp_port_en;

  // Pins are registered; modulation ANDs the odd channel into the even pin
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      compare_pin_out <= 4'h0;
    else
    begin
      compare_pin_out[0] <= cmp_modulation_en[0] ? (nxt_out[0] & nxt_out[1]) : nxt_out[0];
      compare_pin_out[1] <= nxt_out[1];
      compare_pin_out[2] <= cmp_modulation_en[1] ? (nxt_out[2] & nxt_out[3]) : nxt_out[2];
      compare_pin_out[3] <= nxt_out[3];
    end
  end

endmodule // dual_timer_output_compare

`default_nettype wire

// File: dual_timer_output_compare_sva.sv
// Purpose: timing checks on the compare outputs and timer underflow
// Assumes: sees only the top module ports
// Notes: enables are levels, so gating is checked while they are steady
`timescale 1ns/1ps
`default_nettype none
module output_compare_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       first_timer_underflow_irq,
  input wire logic [7:0] first_timer_high_byte,
  input wire logic [7:0] cmp_reload_set,
  input wire logic [7:0] cmp_reload_pending,
  input wire logic [7:0] cmp_int_en,
  input wire logic [7:0] cmp_match_pulse,
  input wire logic       cmp_irq_req,
  input wire logic [3:0] cmp_trigger_en,
  input wire logic [3:0] cmp_polarity,
  input wire logic [3:0] cmp_output_status,
  input wire logic [1:0] cmp_modulation_en,
  input wire logic [3:0] compare_pin_out,
  input wire logic [3:0] cmp_port_en,
  input wire logic [3:0] compare_pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  uflow_at_zero_a: assert property (first_timer_underflow_irq |-> $past(first_timer_high_byte, 1) == 8'h00)
    else $error("underflow without zero count");
  pend_cause_a: assert property ($rose(cmp_reload_pending[0]) |-> $past(cmp_reload_set[0]))
    else $error("pending reload without request");
  irq_gate_a: assert property ($stable(cmp_int_en) |-> cmp_irq_req == |(cmp_match_pulse & cmp_int_en))
    else $error("compare request not gated by enables");
  hold_off_a: assert property (!cmp_trigger_en[0] && !$past(cmp_trigger_en[0]) |-> $stable(cmp_output_status[0]))
    else $error("output moved with trigger disabled");
  status_cause_a: assert property ($changed(cmp_output_status) |-> |cmp_match_pulse)
    else $error("output moved without a match");
  first_level_a: assert property (cmp_match_pulse[0] && !cmp_match_pulse[1] && $past(cmp_trigger_en[0])
    |-> cmp_output_status[0] == !$past(cmp_polarity[0]))
    else $error("wrong level on first latch match");
  second_level_a: assert property (cmp_match_pulse[1] && $past(cmp_trigger_en[0])
    |-> cmp_output_status[0] == $past(cmp_polarity[0]))
    else $error("wrong level on second latch match");
  pair_and_a: assert property (cmp_modulation_en[1] && $past(cmp_modulation_en[1])
    |-> compare_pin_out[2] == (cmp_output_status[2] & cmp_output_status[3]))
    else $error("modulated pin is not the pair AND");
  pin_drive_a: assert property (compare_pin_oe == cmp_port_en && compare_pin_out[1] == cmp_output_status[1]
    && compare_pin_out[3] == cmp_output_status[3])
    else $error("unmodulated pin or pin enable differs from channel state");
endmodule // output_compare_checker
bind dual_timer_output_compare output_compare_checker i_output_compare_checker (.*);
`default_nettype wire

// File: compare_pin_model.sv
// Purpose: port pins seen by the outside world
// Assumes: no pull resistors on the compare pins
// Notes: an undriven pin flips each cycle so a stale level never passes
`timescale 1ns/1ps
`default_nettype none
module compare_pin_model (
  input  wire logic       mclk,
  input  wire logic [3:0] compare_pin_out,
  input  wire logic [3:0] compare_pin_oe,
  output var  logic [3:0] pin_level
);
  logic [3:0] float_ff = 4'h0;
  always @(posedge mclk) float_ff <= ~pin_level;
  assign pin_level = (compare_pin_out & compare_pin_oe) | (float_ff & ~compare_pin_oe);
endmodule // compare_pin_model
`default_nettype wire

// File: dual_timer_output_compare_tb.sv
// Purpose: self-checking bench for the dual timer compare block
// Assumes: driver queues expectations, monitors compare on results
// Notes: timer access, count periods, then compare waveforms
`timescale 1ns/1ps
`default_nettype none
module dual_timer_output_compare_tb;
  logic mclk = 0, rst = 1, onchip_osc = 0, first_timer_stop = 1, second_timer_stop = 0;
  logic first_timer_write_latch_only = 0, second_timer_write_latch_only = 0, sel = 0, rd_d = 0, sd = 0;
  logic first_timer_low_wr = 0, first_timer_high_wr = 0, second_timer_low_wr = 0, second_timer_high_wr = 0;
  logic first_timer_high_rd = 0, second_timer_high_rd = 0, cmp_low_wr = 0, cmp_high_wr = 0;
  logic [7:0] timer_clock_source_select = 8'h77, wr_data = 0, cmp_reload_set = 0, cmp_int_en = 0, hb_d = 0;
  logic [3:0] cmp_timer_source = 0, cmp_trigger_en = 0, cmp_polarity = 0, cmp_port_en = 0, st = 0;
  logic [1:0] cmp_write_pointer = 0, cmp_modulation_en = 0;
  logic [2:0] oc = 0, cd[9] = '{0, 1, 2, 3, 4, 5, 6, 1, 6};
  logic [15:0] v, qr[$];
  logic [7:0] qc[$];
  int qt[$], dv[9] = '{2, 16, 32, 64, 128, 256, 8, 16, 8};
  int n_fail = 0, samples_checked = 0, seed = 32'h45eb, cnt = 0;
  wire [7:0] first_timer_low_byte, first_timer_high_byte, second_timer_low_byte, second_timer_high_byte;
  wire [7:0] cmp_reload_pending, cmp_match_pulse;
  wire [3:0] cmp_output_status, compare_pin_out, compare_pin_oe, pin_level;
  wire       first_timer_underflow_irq, second_timer_underflow_irq, cmp_irq_req;
  wire       irq_s = sel ? second_timer_underflow_irq : first_timer_underflow_irq;
  wire [7:0] lb_s = sd ? second_timer_low_byte : first_timer_low_byte;
  dual_timer_output_compare i_dual_timer_output_compare (.*);
  compare_pin_model i_compare_pin_model (.mclk, .compare_pin_out, .compare_pin_oe, .pin_level);
  initial forever #2.5 mclk = ~mclk;
  task check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    oc <= oc + 1;
    onchip_osc <= oc[2];
    rd_d <= first_timer_high_rd | second_timer_high_rd;
    sd <= sel;
    hb_d <= sel ? second_timer_high_byte : first_timer_high_byte;
    cnt <= irq_s ? 1 : cnt + 1;
    if (rd_d && qr.size() > 0) check("read", {hb_d, lb_s}, qr.pop_front());
    if (irq_s && qt.size() > 0) check("period", cnt, qt.pop_front());
    if (|cmp_match_pulse[2:0] && qc.size() > 0)
      check("match", {cmp_match_pulse[2:0], cmp_output_status[1:0], cmp_irq_req, pin_level[1:0]},
            qc.pop_front());
  end
  task tw(input logic s, input logic [15:0] d);
    @(posedge mclk);
    wr_data <= d[7:0];
    first_timer_low_wr <= !s;
    second_timer_low_wr <= s;
    @(posedge mclk);
    {first_timer_low_wr, second_timer_low_wr} <= 2'h0;
    wr_data <= d[15:8];
    first_timer_high_wr <= !s;
    second_timer_high_wr <= s;
    @(posedge mclk);
    {first_timer_high_wr, second_timer_high_wr} <= 2'h0;
  endtask
  task rd;
    @(posedge mclk);
    first_timer_high_rd <= !sel;
    second_timer_high_rd <= sel;
    @(posedge mclk);
    {first_timer_high_rd, second_timer_high_rd} <= 2'h0;
  endtask
  task cl(input logic [1:0] ch, input logic lt, input logic [15:0] d);
    @(posedge mclk);
    cmp_write_pointer <= ch;
    wr_data <= d[7:0];
    cmp_low_wr <= 1;
    @(posedge mclk);
    cmp_low_wr <= 0;
    cmp_high_wr <= 1;
    wr_data <= d[15:8];
    @(posedge mclk);
    cmp_high_wr <= 0;
    cmp_reload_set <= 8'h01 << {ch, lt};
    @(posedge mclk);
    cmp_reload_set <= 8'h00;
  endtask
  task wu;
    int i;
    @(negedge mclk);
    for (i = 0; i < 3000 && irq_s !== 1'b1; i++) @(negedge mclk);
    if (irq_s !== 1'b1) n_fail++;
  endtask
  task ev(input logic [2:0] m);
    if (m[0] && cmp_trigger_en[0]) st[0] = ~cmp_polarity[0];
    if (m[1] && cmp_trigger_en[0]) st[0] = cmp_polarity[0];
    if (m[2]) st[1] = ~cmp_polarity[1];
    qc.push_back({m, st[1:0], m[0], st[1:0]});
  endtask
  task per(input logic late);
    if (late) ev(3'h4);
    ev(late ? 3'h2 : 3'h1);
    ev(late ? 3'h1 : 3'h4);
    if (!late) ev(3'h2);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 0;
    v = $random(seed);
    tw(0, v);
    qr.push_back(v);
    rd;
    first_timer_write_latch_only <= 1;
    tw(0, ~v);
    qr.push_back(v);
    rd;
    sel <= 1;
    v = $random(seed);
    tw(1, v);
    qr.push_back(v);
    rd;
    $display("timer access test done");
    first_timer_write_latch_only <= 0;
    for (int k = 0; k < 9; k++)
    begin
      sel <= k > 6;
      {first_timer_stop, second_timer_stop} <= 2'h3;
      timer_clock_source_select <= {1'b0, k > 6 ? cd[k] : 3'h7, 1'b0, k > 6 ? 3'h0 : cd[k]};
      tw(0, 16'h0003);
      tw(1, 16'h0001);
      {first_timer_stop, second_timer_stop} <= 2'h0;
      wu;
      wu;
      qt.push_back((k > 6 ? 2 : 4) * dv[k]);
      wu;
      @(posedge mclk);
    end
    $display("count period test done");
    first_timer_stop <= 1;
    sel <= 0;
    timer_clock_source_select <= 8'h60;
    cmp_timer_source <= 4'h8;
    cmp_modulation_en <= 2'b10;
    cmp_port_en <= 4'h7;
    cmp_trigger_en <= 4'hf;
    cmp_polarity <= {v[0], 3'h4};
    cmp_int_en <= 8'h01;
    tw(0, 16'h000f);
    cl(0, 0, 16'h000a);
    cl(0, 1, 16'h0004);
    cl(1, 0, 16'h0007);
    cl(1, 1, 16'h0020);
    per(0);
    first_timer_stop <= 0;
    for (int p = 1; p < 5; p++)
    begin
      wu;
      @(posedge mclk);
      if (p == 1) cmp_polarity[0] <= 1;
      if (p == 2) cmp_trigger_en[0] <= 0;
      if (p == 3) {cmp_trigger_en[0], cmp_polarity[0]} <= 2'b10;
      @(posedge mclk);
      per(p == 4);
      if (p == 3)
      begin
        cl(0, 0, 16'h0002);
        @(negedge mclk);
        check("pending", cmp_reload_pending[0], 1'b1);
      end
    end
    wu;
    repeat (40) @(posedge mclk);
    check("pending events", qc.size(), 0);
    check("pending clear", cmp_reload_pending, 8'h00);
    $display("compare test done");
    results;
  end
  initial
  begin
    #100000;
    n_fail++;
    results;
  end
endmodule // dual_timer_output_compare_tb
`default_nettype wire
